/* design/cfs_pkg.sv */
package cfs_pkg;

  // clock and tick
  localparam int CFS_CLK_PS          = 25000;
  localparam int CFS_TICK_PS         = 4000000;
  localparam int CFS_TICK_CYC        = CFS_TICK_PS / CFS_CLK_PS;
  localparam int CFS_TICK_US         = 4;
  localparam int CFS_TICK_CW         = 8;

  // protection timing in microseconds and ticks
  localparam int CFS_CAL_US          = 250;
  localparam int CFS_UV_DLY_US       = 1000;
  localparam int CFS_UV_ARM_US       = 1500;
  localparam int CFS_SS0_US          = 700;
  localparam int CFS_TW              = 16;
  localparam logic [CFS_TW-1:0] CFS_CAL_TICKS    = CFS_TW'((CFS_CAL_US + CFS_TICK_US - 1) / CFS_TICK_US);
  localparam logic [CFS_TW-1:0] CFS_UV_DLY_TICKS = CFS_TW'((CFS_UV_DLY_US + CFS_TICK_US - 1) / CFS_TICK_US);
  localparam logic [CFS_TW-1:0] CFS_UV_ARM_TICKS = CFS_TW'((CFS_UV_ARM_US + CFS_TICK_US - 1) / CFS_TICK_US);
  localparam logic [CFS_TW-1:0] CFS_TMAX         = 16'hffff;

  // hiccup arithmetic
  localparam int CFS_HIC_EXP_BASE    = 8;
  localparam int CFS_HIC_OFFSET      = 257;
  localparam int CFS_HIC_MULT        = 7;

  // register map
  localparam int CFS_AW              = 4;
  localparam logic [CFS_AW-1:0] CFS_OFF_CTRL   = 4'h0;
  localparam logic [CFS_AW-1:0] CFS_OFF_STATUS = 4'h4;
  localparam logic [CFS_AW-1:0] CFS_OFF_MASK   = 4'h8;
  localparam logic [CFS_AW-1:0] CFS_OFF_STATE  = 4'hc;
  localparam int CFS_EVW             = 5;
  localparam int CFS_EV_OCP          = 0;
  localparam int CFS_EV_UV           = 1;
  localparam int CFS_EV_OV           = 2;
  localparam int CFS_EV_BIAS         = 3;
  localparam int CFS_EV_THERM        = 4;
  localparam logic        CFS_CTRL_RST   = 1'b1;
  localparam logic [CFS_EVW-1:0] CFS_MASK_RST = 5'h00;
  localparam int CFS_ST_SEL_POS      = 4;
  localparam int CFS_ST_HS_POS       = 6;
  localparam int CFS_ST_LS_POS       = 7;

  typedef enum logic [2:0] {
    CFS_IDLE, CFS_CAL, CFS_SOFT, CFS_RUN, CFS_UV_OFF, CFS_OV_PULL, CFS_OV_OFF
  } cfs_state_t;

  // soft-start length: 0.7 ms doubled per selection step
  function automatic logic [CFS_TW-1:0] cfs_ss_ticks(input logic [1:0] sel);
    cfs_ss_ticks = CFS_TW'(((CFS_SS0_US << sel) + CFS_TICK_US - 1) / CFS_TICK_US);
  endfunction : cfs_ss_ticks

  // wait time (2^n + 257) ticks, n = 8 + sel
  function automatic logic [CFS_TW-1:0] cfs_hic_wait(input logic [1:0] sel);
    cfs_hic_wait = CFS_TW'((1 << (CFS_HIC_EXP_BASE + sel)) + CFS_HIC_OFFSET);
  endfunction : cfs_hic_wait

  function automatic logic [CFS_TW-1:0] cfs_hic_delay(input logic [1:0] sel);
    cfs_hic_delay = CFS_TW'(CFS_HIC_MULT * int'(cfs_hic_wait(sel)));
  endfunction : cfs_hic_delay

endpackage : cfs_pkg

/* design/cfs_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module cfs_tick_gen
  import cfs_pkg::*;
(
  input  wire logic mclk,
  input  wire logic resetn,
  output logic      tick
);

  logic [CFS_TICK_CW-1:0] cnt_reg;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (cnt_reg == CFS_TICK_CW'(CFS_TICK_CYC - 1)) begin
      cnt_reg <= '0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick    <= 1'b0;
    end
  end

  chk_tick_spacing: assert property (@(posedge mclk) disable iff (!resetn) tick |=> !tick[*8]) else $error("tick too close");

endmodule : cfs_tick_gen
`default_nettype wire

/* design/cfs_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - hold off state while overcurrent flag high
// - overcurrent checked only in off state
// - undervoltage shutdown restarts after hiccup, repeats
// - wait (2^n+257) ticks, delay seven times
// - timing per soft-start selection as tabulated
// - undervoltage persisting 1 ms latches both off
// - undervoltage latch restarts after hiccup delay
// - undervoltage ignored until 1.5 ms after soft-start
// - overvoltage forces high off, low on
// - low stays on until 1 ms undervoltage
// - backup overvoltage input engages same response
// - bias lockout shuts down, non-latching
// - over-temperature shuts down, non-latching
// - mode resistor code selects soft-start time
module cfs_sequencer
  import cfs_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              enable_in,
  input  wire logic [1:0]        mode_sel,
  input  wire logic              bias_lockout,
  input  wire logic              over_temp,
  input  wire logic              overcurrent_guard,
  input  wire logic              undervoltage_guard,
  input  wire logic              overvoltage_guard,
  input  wire logic              backup_overvoltage_sense,
  input  wire logic              pwm_on_req,
  input  wire logic              on_time_done,
  input  wire logic [CFS_AW-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   hs_gate_en,
  output logic                   ls_gate_en,
  output logic                   soft_start_done,
  output logic                   irq
);

  cfs_state_t           state_reg;
  cfs_state_t           state_next;
  logic                 tick;
  logic [CFS_TW-1:0]    timer_reg;
  logic [CFS_TW-1:0]    uv_cnt_reg;
  logic [1:0]           ss_sel_reg;
  logic                 phase_on_reg;
  logic                 sw_enable_reg;
  logic [CFS_EVW-1:0]   status_reg;
  logic [CFS_EVW-1:0]   mask_reg;
  logic [CFS_EVW-1:0]   events;
  logic                 fault_stop;
  logic                 ov_any;
  logic                 switching;
  logic                 uv_armed;
  logic                 uv_expired;

  cfs_tick_gen u_tick (
    .mclk   (mclk),
    .resetn (resetn),
    .tick   (tick)
  );

  // shutdown causes are levels; comparator hysteresis lives in the analog front
  assign fault_stop = bias_lockout || over_temp || !enable_in || !sw_enable_reg;
  assign ov_any     = overvoltage_guard || backup_overvoltage_sense;
  assign switching  = (state_reg == CFS_SOFT) || (state_reg == CFS_RUN);
  assign uv_armed   = (state_reg == CFS_RUN) && (timer_reg >= CFS_UV_ARM_TICKS);
  assign uv_expired = (uv_cnt_reg >= CFS_UV_DLY_TICKS);

  always_comb begin
    state_next = state_reg;
    if (fault_stop) begin
      state_next = CFS_IDLE;
    end else begin
      case (state_reg)
        CFS_IDLE: begin
          state_next = CFS_CAL;
        end
        CFS_CAL: begin
          if (timer_reg >= CFS_CAL_TICKS) begin
            state_next = CFS_SOFT;
          end
        end
        CFS_SOFT: begin
          if (ov_any) begin
            state_next = CFS_OV_PULL;
          end else if (timer_reg >= cfs_ss_ticks(ss_sel_reg)) begin
            state_next = CFS_RUN;
          end
        end
        CFS_RUN: begin
          if (ov_any) begin
            state_next = CFS_OV_PULL;
          end else if (uv_armed && uv_expired) begin
            state_next = CFS_UV_OFF;
          end
        end
        CFS_UV_OFF: begin
          // hiccup: wait out the delay, then soft start again; loops while the fault lasts
          if (timer_reg >= cfs_hic_delay(ss_sel_reg)) begin
            state_next = CFS_SOFT;
          end
        end
        CFS_OV_PULL: begin
          if (uv_expired) begin
            state_next = CFS_OV_OFF;
          end
        end
        CFS_OV_OFF: begin
          state_next = CFS_OV_OFF;
        end
        default: begin
          state_next = CFS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg <= CFS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // one tick-based timer per state; saturates so long runs stay armed
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      timer_reg <= '0;
    end else if (state_next != state_reg) begin
      timer_reg <= '0;
    end else if (tick && timer_reg != CFS_TMAX) begin
      timer_reg <= timer_reg + 1'b1;
    end
  end

  // undervoltage persistence; any gap restarts the count
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      uv_cnt_reg <= '0;
    end else if (!undervoltage_guard || !(uv_armed || state_reg == CFS_OV_PULL)) begin
      uv_cnt_reg <= '0;
    end else if (tick && uv_cnt_reg != CFS_TMAX) begin
      uv_cnt_reg <= uv_cnt_reg + 1'b1;
    end
  end

  // selection is sampled once per start-up, at the end of calibration
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ss_sel_reg <= 2'h0;
    end else if (state_reg == CFS_CAL && state_next == CFS_SOFT) begin
      ss_sel_reg <= mode_sel;
    end
  end

  // switching phase: off ends only when the loop asks and current is below trip
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      phase_on_reg <= 1'b0;
    end else if (!switching) begin
      phase_on_reg <= 1'b0;
    end else if (phase_on_reg) begin
      if (on_time_done) begin
        phase_on_reg <= 1'b0;
      end
    end else if (pwm_on_req && !overcurrent_guard) begin
      phase_on_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hs_gate_en      <= 1'b0;
      ls_gate_en      <= 1'b0;
      soft_start_done <= 1'b0;
    end else begin
      hs_gate_en      <= switching && phase_on_reg;
      ls_gate_en      <= (switching && !phase_on_reg) || (state_reg == CFS_OV_PULL);
      soft_start_done <= (state_reg == CFS_RUN);
    end
  end

  assign events[CFS_EV_OCP]   = switching && !phase_on_reg && pwm_on_req && overcurrent_guard;
  assign events[CFS_EV_UV]    = (state_reg == CFS_RUN) && (state_next == CFS_UV_OFF);
  assign events[CFS_EV_OV]    = (state_next == CFS_OV_PULL) && (state_reg != CFS_OV_PULL);
  assign events[CFS_EV_BIAS]  = bias_lockout;
  assign events[CFS_EV_THERM] = over_temp;

  // a new event in the clearing cycle stays set
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      status_reg <= '0;
    end else if (reg_wr && reg_addr == CFS_OFF_STATUS) begin
      status_reg <= (status_reg & ~reg_wdata[CFS_EVW-1:0]) | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sw_enable_reg <= CFS_CTRL_RST;
      mask_reg      <= CFS_MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == CFS_OFF_CTRL) begin
        sw_enable_reg <= reg_wdata[0];
      end
      if (reg_addr == CFS_OFF_MASK) begin
        mask_reg <= reg_wdata[CFS_EVW-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // read data live for exactly the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!resetn || !reg_rd) begin
      reg_rdata <= 32'h0;
    end else begin
      case (reg_addr)
        CFS_OFF_CTRL:   reg_rdata <= {31'h0, sw_enable_reg};
        CFS_OFF_STATUS: reg_rdata <= {27'h0, status_reg};
        CFS_OFF_MASK:   reg_rdata <= {27'h0, mask_reg};
        CFS_OFF_STATE:  reg_rdata <= {24'h0, ls_gate_en, hs_gate_en, ss_sel_reg, 1'b0, state_reg};
        default:        reg_rdata <= 32'h0;
      endcase
    end
  end

  chk_ocp_hold_off: assert property (@(posedge mclk) disable iff (!resetn)
    (!phase_on_reg && overcurrent_guard) |=> !phase_on_reg)
    else $error("on phase began while overcurrent high");

  chk_ocp_blind_on: assert property (@(posedge mclk) disable iff (!resetn)
    (phase_on_reg && !on_time_done && switching && !fault_stop && !ov_any) |=> phase_on_reg)
    else $error("on phase cut by overcurrent");

  chk_hiccup_length: assert property (@(posedge mclk) disable iff (!resetn)
    (state_reg == CFS_SOFT && $past(state_reg) == CFS_UV_OFF)
      |-> $past(timer_reg) >= cfs_hic_delay(ss_sel_reg))
    else $error("hiccup restart too early");

  chk_uv_latch_both: assert property (@(posedge mclk) disable iff (!resetn)
    (state_reg == CFS_UV_OFF) |=> (!hs_gate_en && !ls_gate_en))
    else $error("driver on in undervoltage latch");

  chk_uv_persist: assert property (@(posedge mclk) disable iff (!resetn)
    (state_reg == CFS_UV_OFF && $past(state_reg) == CFS_RUN) |-> $past(uv_cnt_reg) >= CFS_UV_DLY_TICKS)
    else $error("undervoltage latched before 1 ms");

  chk_uv_unarmed: assert property (@(posedge mclk) disable iff (!resetn)
    (state_reg == CFS_RUN && timer_reg < CFS_UV_ARM_TICKS) |=> state_reg != CFS_UV_OFF)
    else $error("undervoltage acted before arming");

  chk_ov_pull_low: assert property (@(posedge mclk) disable iff (!resetn)
    (ov_any && state_reg == CFS_RUN && !fault_stop) |=> ##1 (ls_gate_en && !hs_gate_en))
    else $error("overvoltage did not pull low");

  chk_ov_release: assert property (@(posedge mclk) disable iff (!resetn)
    (state_reg == CFS_OV_OFF && $past(state_reg) == CFS_OV_PULL) |-> $past(uv_cnt_reg) >= CFS_UV_DLY_TICKS)
    else $error("overvoltage latch-off too early");

  chk_bias_stop: assert property (@(posedge mclk) disable iff (!resetn)
    bias_lockout |=> ##1 (!hs_gate_en && !ls_gate_en))
    else $error("drivers on under bias lockout");

  chk_therm_stop: assert property (@(posedge mclk) disable iff (!resetn)
    over_temp |=> (state_reg == CFS_IDLE))
    else $error("no shutdown on over-temperature");

  chk_mode_capture: assert property (@(posedge mclk) disable iff (!resetn)
    (state_reg == CFS_SOFT && $past(state_reg) == CFS_CAL) |-> ss_sel_reg == $past(mode_sel))
    else $error("soft-start selection not captured");

  chk_restart_path: assert property (@(posedge mclk) disable iff (!resetn)
    ($past(state_reg) == CFS_IDLE && state_reg != CFS_IDLE) |-> state_reg == CFS_CAL)
    else $error("recovery skipped start-up sequence");

endmodule : cfs_sequencer
`default_nettype wire

/* bench/cfs_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
// power stage and on-time one-shot: ends each on phase after a fixed span of high-side conduction
module cfs_stage_model #(
  parameter int ON_CYC = 4
) (
  input  wire logic mclk,
  input  wire logic go,
  input  wire logic hs_gate_en,
  output logic      pwm_on_req,
  output logic      on_time_done
);
  int on_cnt = 0;
  // loop request is a plain level; the stage never asks while go is low
  assign pwm_on_req   = go;
  // one-shot expires only after real high-side conduction, so a held-off switch never times out
  assign on_time_done = (on_cnt >= ON_CYC);
  always_ff @(posedge mclk) begin
    on_cnt <= hs_gate_en ? on_cnt + 1 : 0;
  end
endmodule : cfs_stage_model
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cfs_pkg::*;
  localparam int TC = 160;
  logic mclk = 0, resetn = 0, enable_in = 1, bias_lockout = 0, over_temp = 0, oc = 0, uv = 0, ov = 0, bov = 0;
  logic go = 0, pwm_on_req, on_time_done, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [1:0] mode_sel = 2'h0;
  logic [CFS_AW-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, mval;
  logic hs_gate_en, ls_gate_en, soft_start_done, irq;
  logic [63:0] expq[$];
  int err_count = 0, tests_run = 0, i, cnt;
  cfs_sequencer DUT (.mclk(mclk), .resetn(resetn), .enable_in(enable_in), .mode_sel(mode_sel),
    .bias_lockout(bias_lockout), .over_temp(over_temp), .overcurrent_guard(oc), .undervoltage_guard(uv),
    .overvoltage_guard(ov), .backup_overvoltage_sense(bov), .pwm_on_req(pwm_on_req),
    .on_time_done(on_time_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hs_gate_en(hs_gate_en), .ls_gate_en(ls_gate_en),
    .soft_start_done(soft_start_done), .irq(irq));
  cfs_stage_model #(.ON_CYC(4)) stage (.mclk(mclk), .go(go), .hs_gate_en(hs_gate_en),
    .pwm_on_req(pwm_on_req), .on_time_done(on_time_done));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [CFS_AW-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // expected value and compare mask travel together; the monitor pops them when data appear
  task automatic rd(input logic [CFS_AW-1:0] a, input logic [31:0] exp, input logic [31:0] msk);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    expq.push_back({exp & msk, msk});
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  always @(posedge mclk) begin
    logic [63:0] e;
    if (rd_d) begin
      e = expq.pop_front();
      check(reg_rdata & e[31:0], e[63:32]);
    end
    rd_d <= reg_rd;
  end
  initial begin
    // full run is about 80k cycles; stay under the 95k-cycle watchdog
    #(95000 * 25);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
  initial begin
    void'($urandom(32'hc18790e5));
    cyc(8);
    resetn <= 1'b1;
    rd(CFS_OFF_MASK, 32'h0, 32'hffffffff);
    rd(CFS_OFF_CTRL, 32'h1, 32'hffffffff);
    rd(4'h2, 32'h0, 32'hffffffff);
    rd(CFS_OFF_STATE, 32'h01, 32'hff);
    mval = $urandom & 32'h1f;
    wr(CFS_OFF_MASK, mval);
    rd(CFS_OFF_MASK, mval, 32'hffffffff);
    wr(CFS_OFF_MASK, 32'h1f);
    // calibration plus 0.7 ms soft start, counted in whole ticks
    for (cnt = 0; cnt < 45000 && soft_start_done !== 1'b1; cnt++) @(posedge mclk);
    check((cnt >= 237 * TC) && (cnt <= 240 * TC), 1'b1);
    rd(CFS_OFF_STATE, 32'h03, 32'h3f);
    // undervoltage raised early in run must be ignored until armed
    oc <= 1'b1; go <= 1'b1; uv <= 1'b1;
    cyc(20);
    check(hs_gate_en, 1'b0);
    rd(CFS_OFF_STATE, 32'h83, 32'hff);
    check(irq, 1'b1);
    rd(CFS_OFF_STATUS, 32'h01, 32'h01);
    oc <= 1'b0; uv <= 1'b0;
    for (i = 0; i < 20 && hs_gate_en !== 1'b1; i++) @(posedge mclk);
    check(hs_gate_en, 1'b1);
    oc <= 1'b1; go <= 1'b0;
    cyc(2);
    check(hs_gate_en, 1'b1);
    for (i = 0; i < 20 && hs_gate_en !== 1'b0; i++) @(posedge mclk);
    check(hs_gate_en, 1'b0);
    oc <= 1'b0;
    wr(CFS_OFF_STATUS, 32'h1f);
    rd(CFS_OFF_STATUS, 32'h0, 32'h1f);
    cyc(3);
    check(irq, 1'b0);
    wr(CFS_OFF_MASK, 32'h0);
    bov <= 1'b1;
    cyc(4);
    bov <= 1'b0;
    rd(CFS_OFF_STATE, 32'h85, 32'hff);
    check(irq, 1'b0);
    rd(CFS_OFF_STATUS, 32'h04, 32'h04);
    wr(CFS_OFF_MASK, 32'h04);
    cyc(2);
    check(irq, 1'b1);
    // low side must keep pulling until the output has sat under the low threshold for 1 ms
    uv <= 1'b1;
    cyc(245 * TC);
    rd(CFS_OFF_STATE, 32'h85, 32'hff);
    cyc(8 * TC);
    rd(CFS_OFF_STATE, 32'h06, 32'hff);
    check(ls_gate_en, 1'b0);
    uv <= 1'b0;
    bias_lockout <= 1'b1;
    cyc(3);
    rd(CFS_OFF_STATE, 32'h00, 32'hcf);
    rd(CFS_OFF_STATUS, 32'h08, 32'h08);
    bias_lockout <= 1'b0;
    cyc(3);
    rd(CFS_OFF_STATE, 32'h01, 32'hcf);
    over_temp <= 1'b1;
    cyc(3);
    rd(CFS_OFF_STATE, 32'h00, 32'hcf);
    rd(CFS_OFF_STATUS, 32'h10, 32'h10);
    over_temp <= 1'b0;
    cyc(3);
    rd(CFS_OFF_STATE, 32'h01, 32'hcf);
    cyc(3);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
